// ---- hw/fpd_pkg.sv ----
// constants, types and frame carrier for the power-down and identification command logic
package fpd_pkg;

  // opcodes recognised by this block
  localparam logic [7:0] FPD_OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] FPD_OP_RELEASE = 8'hab;
  localparam logic [7:0] FPD_OP_MFR_DEV_ID = 8'h90;
  localparam logic [7:0] FPD_OP_UNIQUE_ID = 8'h4b;
  localparam logic [7:0] FPD_OP_STD_ID = 8'h9f;

  // continuous-read mode: active pattern and the reset words
  localparam logic [3:0] FPD_CR_ACTIVE_NIBBLE = 4'ha;
  localparam logic [7:0] FPD_CR_RESET_QUAD = 8'hff;
  localparam logic [15:0] FPD_CR_RESET_DUAL = 16'hffff;

  // bit counts inside a frame (link clock rising edges)
  localparam int FPD_CNT_W = 6;
  localparam logic [5:0] FPD_CNT_MAX = 6'h3f;
  localparam logic [5:0] FPD_OP_BITS = 6'h08;
  localparam logic [5:0] FPD_LEGACY_START = 6'h20;
  localparam logic [5:0] FPD_MFR_START = 6'h20;
  localparam logic [5:0] FPD_UID_START = 6'h28;
  localparam logic [5:0] FPD_STD_START = 6'h08;
  localparam logic [5:0] FPD_CR_QUAD_BITS = 6'h08;
  localparam logic [5:0] FPD_CR_DUAL_BITS = 6'h10;

  // last byte index of each repeating id stream
  localparam logic [2:0] FPD_LEGACY_LAST = 3'h0;
  localparam logic [2:0] FPD_MFR_LAST = 3'h1;
  localparam logic [2:0] FPD_STD_LAST = 3'h2;
  localparam logic [2:0] FPD_UID_LAST = 3'h7;

  // times in ns, cycle counts derived at the core clock rate
  localparam int FPD_CLK_MHZ = 125;
  localparam int FPD_POWER_DOWN_ENTRY_TIME_NS = 3000;
  localparam int FPD_RELEASE_TIME_NS = 3000;
  localparam int FPD_RELEASE_WITH_ID_TIME_NS = 1800;
  localparam int FPD_TMR_W = 12;

  // longest times round down, never below one cycle
  function automatic int fpd_cyc_floor(input int ns);
    int c;
    c = (ns * FPD_CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [11:0] FPD_PD_ENTRY_CYC = 12'(fpd_cyc_floor(FPD_POWER_DOWN_ENTRY_TIME_NS));
  localparam logic [11:0] FPD_RELEASE_CYC = 12'(fpd_cyc_floor(FPD_RELEASE_TIME_NS));
  localparam logic [11:0] FPD_RELEASE_ID_CYC = 12'(fpd_cyc_floor(FPD_RELEASE_WITH_ID_TIME_NS));

  typedef enum logic [1:0] {
    FPD_ST_NORMAL,
    FPD_ST_ENTERING,
    FPD_ST_DOWN,
    FPD_ST_RELEASING
  } fpd_state_t;

  typedef enum logic [2:0] {
    FPD_MD_NONE,
    FPD_MD_LEGACY,
    FPD_MD_MFR,
    FPD_MD_UID,
    FPD_MD_STD
  } fpd_mode_t;

  // summary of one frame handed from the link domain to the core
  typedef struct packed {
    logic tog;
    logic [5:0] bits;
    logic [7:0] op;
    logic [15:0] last;
  } fpd_frame_t;

endpackage

// ---- hw/fpd_cmd.sv ----
// power-down, release and identification command logic of a serial flash
//
// Operation
// - power-down runs only if chip select rises right after opcode bit eight
// - after a valid power-down frame the low-power state is reached within entry time
// - while powered down only the release opcode is recognised
// - device comes out of reset in normal operation
// - release opcode plus chip select high ends power-down after release time
// - release opcode plus three dummy bytes shifts out device id, msb first, except while powered down
// - legacy device id repeats until chip select rises
// - release/id opcode is ignored while an erase, program or write runs
// - opcode 90h with address 000000h returns manufacturer then device id
// - address 000001h returns device id first, then the two alternate
// - opcode 4Bh plus four dummy bytes shifts out the 64-bit unique number
// - opcode 9Fh returns manufacturer, memory type and capacity bytes
// - continuous-read bits Ax let the next dual/quad read skip its opcode
// - with continuous-read bits Ax standard instructions are not decoded
// - eight clocks of FFh clear continuous-read mode left by quad read
// - sixteen clocks of FFFFh clear continuous-read mode left by dual read
// - busy status is 1 while a self-timed cycle runs, else 0
`timescale 1ns/100ps
module fpd_cmd
  import fpd_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,         // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3c,      // arbitrary value
  parameter logic [7:0] MEMORY_TYPE_BYTE = 8'h21, // arbitrary value
  parameter logic [7:0] CAPACITY_BYTE = 8'h15,  // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic busy_in,
  input wire logic cr_load_in,
  input wire logic [7:0] continuous_read_bits_in,
  input wire logic cr_quad_in,
  output logic power_down_out,
  output logic ready_out,
  output logic cont_read_out,
  output logic status_busy_out
);

  // ---------------------------------------------------------------- core side
  fpd_state_t state_ff, nxt_state;
  logic [FPD_TMR_W-1:0] tmr_ff, nxt_tmr;
  logic link_rst_ff;
  logic cr_mode_ff, cr_quad_ff;
  logic pd_out_ff, ready_ff, busy_ff;

  // ---------------------------------------------------------------- link side
  logic first_ff, tog_ff;
  logic [5:0] cnt_ff;
  logic [15:0] shift_ff;
  logic [7:0] op_ff;
  fpd_mode_t mode_ff;
  logic tx_on_ff;
  logic [2:0] byte_ff, bit_ff;
  logic so_ff, oe_ff;
  logic [2:0] lsync1_ff, lsync2_ff;

  // link reset: held by the core while its own reset is low
  always_ff @(posedge clock_in) begin
    link_rst_ff <= ~resetn_in;
  end

  // core levels into the link domain; cleared each frame, fresh by edge 2
  always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lsync1_ff <= 3'h0;
      lsync2_ff <= 3'h0;
    end else begin
      lsync1_ff <= {state_ff != FPD_ST_NORMAL, busy_in, cr_mode_ff};
      lsync2_ff <= lsync1_ff;
    end
  end

  wire pd_s = lsync2_ff[2];
  wire busy_s = lsync2_ff[1];
  wire cr_s = lsync2_ff[0];

  // bit counting and input shift, saturating so long frames stay distinct
  wire [5:0] nxt_cnt = ~first_ff ? 6'h01 : (cnt_ff == FPD_CNT_MAX) ? cnt_ff : cnt_ff + 6'h01;
  wire [15:0] nxt_shift = {(first_ff ? shift_ff[14:0] : 15'h0000), mosi_in};
  wire op_edge = (nxt_cnt == FPD_OP_BITS);
  wire [7:0] nxt_op = nxt_shift[7:0];

  // opcode decode; nothing decodes in continuous-read mode
  wire dec_ok = ~pd_s & ~cr_s;
  wire dec_legacy = dec_ok & ~busy_s & (nxt_op == FPD_OP_RELEASE);
  wire dec_mfr = dec_ok & (nxt_op == FPD_OP_MFR_DEV_ID);
  wire dec_uid = dec_ok & (nxt_op == FPD_OP_UNIQUE_ID);
  wire dec_std = dec_ok & (nxt_op == FPD_OP_STD_ID);
  fpd_mode_t dec_mode;
  always_comb begin
    dec_mode = FPD_MD_NONE;
    if (dec_legacy) dec_mode = FPD_MD_LEGACY;
    else if (dec_mfr) dec_mode = FPD_MD_MFR;
    else if (dec_uid) dec_mode = FPD_MD_UID;
    else if (dec_std) dec_mode = FPD_MD_STD;
  end
  wire fpd_mode_t nxt_mode = op_edge ? dec_mode : mode_ff;

  // first data bit position and stream length per command
  logic [5:0] start_bits;
  logic [2:0] last_byte;
  always_comb begin
    case (nxt_mode)
      FPD_MD_LEGACY: begin
        start_bits = FPD_LEGACY_START;
        last_byte = FPD_LEGACY_LAST;
      end
      FPD_MD_MFR: begin
        start_bits = FPD_MFR_START;
        last_byte = FPD_MFR_LAST;
      end
      FPD_MD_UID: begin
        start_bits = FPD_UID_START;
        last_byte = FPD_UID_LAST;
      end
      FPD_MD_STD: begin
        start_bits = FPD_STD_START;
        last_byte = FPD_STD_LAST;
      end
      default: begin
        start_bits = FPD_CNT_MAX;
        last_byte = 3'h0;
      end
    endcase
  end
  wire tx_start = ~tx_on_ff & (nxt_mode != FPD_MD_NONE) & (nxt_cnt == start_bits);
  wire mfr_swap = (nxt_mode == FPD_MD_MFR) & mosi_in;

  // frame record kept after chip select rises, so the core can read it
  always_ff @(posedge spi_clk_in or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      tog_ff <= 1'b0;
      cnt_ff <= 6'h00;
      shift_ff <= 16'h0000;
      op_ff <= 8'h00;
    end else begin
      tog_ff <= first_ff ? tog_ff : ~tog_ff;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      op_ff <= op_edge ? nxt_op : op_ff;
    end
  end

  // per-frame control, cleared the moment chip select rises
  always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      first_ff <= 1'b0;
      mode_ff <= FPD_MD_NONE;
      tx_on_ff <= 1'b0;
      byte_ff <= 3'h0;
      bit_ff <= 3'h7;
    end else begin
      first_ff <= 1'b1;
      mode_ff <= nxt_mode;
      if (tx_start) begin
        tx_on_ff <= 1'b1;
        byte_ff <= mfr_swap ? 3'h1 : 3'h0;
        bit_ff <= 3'h7;
      end else if (tx_on_ff) begin
        bit_ff <= bit_ff - 3'h1;
        if (bit_ff == 3'h0) begin
          byte_ff <= (byte_ff == last_byte) ? 3'h0 : byte_ff + 3'h1;
        end
      end
    end
  end

  // outgoing byte select, msb first
  wire [63:0] uid_rot = UNIQUE_ID << {byte_ff, 3'h0};
  logic [7:0] tx_byte;
  always_comb begin
    case (mode_ff)
      FPD_MD_LEGACY: tx_byte = DEVICE_ID;
      FPD_MD_MFR: tx_byte = (byte_ff == 3'h0) ? MFR_ID : DEVICE_ID;
      FPD_MD_UID: tx_byte = uid_rot[63:56];
      FPD_MD_STD: begin
        case (byte_ff)
          3'h0: tx_byte = MFR_ID;
          3'h1: tx_byte = MEMORY_TYPE_BYTE;
          default: tx_byte = CAPACITY_BYTE;
        endcase
      end
      default: tx_byte = 8'h00;
    endcase
  end
  wire tx_bit = tx_byte[bit_ff];

  // data launched on falling edges; enable only while id bits flow
  always_ff @(negedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      so_ff <= tx_bit;
      oe_ff <= tx_on_ff;
    end
  end
  assign so_out = so_ff;
  assign so_oe_out = oe_ff;

  // ------------------------------------------------- crossing into the core
  logic [2:0] cs_sync_ff;
  fpd_frame_t fr1_ff, fr2_ff;
  logic seen_tog_ff;
  fpd_frame_t fr_link;
  assign fr_link = '{tog: tog_ff, bits: cnt_ff, op: op_ff, last: shift_ff};

  // a frame with no clock edges leaves the toggle alone and is ignored
  wire frame_end = cs_sync_ff[1] & ~cs_sync_ff[2] & (fr2_ff.tog != seen_tog_ff);

  // chip select level and the frame word; the word is static while cs is high
  always_ff @(posedge clock_in) begin
    if (~resetn_in) begin
      cs_sync_ff <= 3'h7;
      fr1_ff <= '0;
      fr2_ff <= '0;
      seen_tog_ff <= 1'b0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n_in};
      fr1_ff <= fr_link;
      fr2_ff <= fr1_ff;
      if (frame_end) seen_tog_ff <= fr2_ff.tog;
    end
  end

  // frame classification
  wire exact_op = (fr2_ff.bits == FPD_OP_BITS);
  wire pd_cmd = frame_end & exact_op & (fr2_ff.op == FPD_OP_POWER_DOWN) & ~cr_mode_ff;
  wire rel_cmd = frame_end & (fr2_ff.bits >= FPD_OP_BITS) & (fr2_ff.op == FPD_OP_RELEASE)
    & ~busy_in;
  wire cr_quad_clr = exact_op & (fr2_ff.last[7:0] == FPD_CR_RESET_QUAD);
  wire cr_dual_clr = (fr2_ff.bits == FPD_CR_DUAL_BITS) & (fr2_ff.last == FPD_CR_RESET_DUAL);
  wire cr_clr = frame_end & cr_mode_ff & (cr_quad_ff ? cr_quad_clr : cr_dual_clr);
  wire cr_set = cr_load_in & (continuous_read_bits_in[7:4] == FPD_CR_ACTIVE_NIBBLE);
  wire tmr_zero = (tmr_ff == '0);

  // power state sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_zero ? tmr_ff : tmr_ff - 12'h001;
    case (state_ff)
      FPD_ST_NORMAL: begin
        if (pd_cmd) begin
          nxt_state = FPD_ST_ENTERING;
          nxt_tmr = FPD_PD_ENTRY_CYC - 12'h001;
        end
      end
      FPD_ST_ENTERING, FPD_ST_DOWN: begin
        if (rel_cmd) begin
          nxt_state = FPD_ST_RELEASING;
          nxt_tmr = exact_op ? FPD_RELEASE_CYC - 12'h001 : FPD_RELEASE_ID_CYC - 12'h001;
        end else if (state_ff == FPD_ST_ENTERING && tmr_zero) begin
          nxt_state = FPD_ST_DOWN;
        end
      end
      FPD_ST_RELEASING: begin
        if (tmr_zero) nxt_state = FPD_ST_NORMAL;
      end
      default: nxt_state = FPD_ST_NORMAL;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (~resetn_in) begin
      state_ff <= FPD_ST_NORMAL;
      tmr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
    end
  end

  // continuous-read mode; a new load wins over a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (~resetn_in) begin
      cr_mode_ff <= 1'b0;
      cr_quad_ff <= 1'b0;
    end else if (cr_set) begin
      cr_mode_ff <= 1'b1;
      cr_quad_ff <= cr_quad_in;
    end else if (cr_load_in || cr_clr) begin
      cr_mode_ff <= 1'b0;
    end
  end

  // status outputs, registered
  always_ff @(posedge clock_in) begin
    if (~resetn_in) begin
      pd_out_ff <= 1'b0;
      ready_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      pd_out_ff <= (nxt_state == FPD_ST_DOWN);
      ready_ff <= (nxt_state == FPD_ST_NORMAL);
      busy_ff <= busy_in;
    end
  end
  assign power_down_out = pd_out_ff;
  assign ready_out = ready_ff;
  assign cont_read_out = cr_mode_ff;
  assign status_busy_out = busy_ff;

endmodule // fpd_cmd

// ---- sim/fpd_cmd_monitor.sv ----
// port checks for the power-down and id command block
`timescale 1ns/100ps
module fpd_cmd_monitor (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic cs_n_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic busy_in,
  input wire logic cr_load_in,
  input wire logic [7:0] continuous_read_bits_in,
  input wire logic power_down_out,
  input wire logic ready_out,
  input wire logic cont_read_out,
  input wire logic status_busy_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // entry and wake windows around the 375 and 225 cycle counts
  sequence s_entered;
    ##[360:385] power_down_out;
  endsequence
  sequence s_woke;
    ##[200:385] ready_out;
  endsequence
  chk_reset_normal: assert property ($rose(resetn_in) |=> ready_out && !power_down_out)
    else $error("not in normal operation after reset");
  chk_entry_time: assert property ($fell(ready_out) |-> s_entered)
    else $error("power-down not reached in entry time");
  chk_wake_time: assert property ($fell(power_down_out) |-> s_woke)
    else $error("normal operation not resumed in time");
  chk_state_excl: assert property (!(power_down_out && ready_out))
    else $error("powered down and ready together");
  chk_down_silent: assert property (power_down_out |-> !so_oe_out)
    else $error("output driven while powered down");
  chk_cs_idle: assert property (cs_n_in |-> !so_oe_out && !so_out)
    else $error("output active while deselected");
  chk_busy_mirror: assert property ($changed(busy_in) |=> status_busy_out == $past(busy_in))
    else $error("busy status does not follow engine");
  chk_cont_load: assert property (cr_load_in && continuous_read_bits_in[7:4] == 4'ha
    |=> cont_read_out)
    else $error("continuous-read mode not entered");
  chk_cont_quiet: assert property (cont_read_out |-> !so_oe_out)
    else $error("output driven in continuous-read mode");
endmodule // fpd_cmd_monitor

bind fpd_cmd fpd_cmd_monitor mon_u (.clock_in(clock_in), .resetn_in(resetn_in),
  .cs_n_in(cs_n_in), .so_out(so_out), .so_oe_out(so_oe_out), .busy_in(busy_in),
  .cr_load_in(cr_load_in), .continuous_read_bits_in(continuous_read_bits_in),
  .power_down_out(power_down_out), .ready_out(ready_out),
  .cont_read_out(cont_read_out), .status_busy_out(status_busy_out));

// ---- sim/fpd_host_model.sv ----
// spi host model, mode 0, 80 ns link clock only inside frames
`timescale 1ns/100ps
module fpd_host_model (
  input wire logic so_in,
  input wire logic oe_in,
  output logic spi_clk_out,
  output logic cs_n_out,
  output logic mosi_out,
  output logic [7:0] rx_byte_out,
  output logic rx_stb_out,
  output logic [7:0] oe_cnt_out
);
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_stb_out = 1'b0;
    oe_cnt_out = 8'h00;
  end
  // one frame: ntx bits out msb first, then nrx bits sampled on rising edges
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx);
    logic [7:0] sh;
    #3.3 cs_n_out = 1'b0;
    oe_cnt_out = 8'h00;
    for (int i = 0; i < ntx + nrx; i++) begin
      mosi_out = (i < ntx) ? tx[ntx-1-i] : ~mosi_out; // no stale value after opcode
      #40 spi_clk_out = 1'b1;
      if (i >= ntx) begin
        sh = {sh[6:0], oe_in ? so_in : 1'b1}; // weak pull-up when undriven
        oe_cnt_out = oe_cnt_out + 8'(oe_in);
        rx_byte_out = sh;
        rx_stb_out = ((i - ntx) % 8 == 7);
      end
      #40 spi_clk_out = 1'b0;
      rx_stb_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule // fpd_host_model

// ---- sim/testbench.sv ----
// self-checking bench for the power-down and id command block
`timescale 1ns/100ps
module testbench;
  import fpd_pkg::*;
  localparam logic [7:0] MFR = 8'hc3; // arbitrary value
  localparam logic [7:0] DEV = 8'h6e; // arbitrary value
  localparam logic [7:0] TYP = 8'h41;
  localparam logic [7:0] CAP = 8'h17;
  localparam logic [63:0] UID = 64'h8badf00d_1357_9bdf;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic busy_in = 1'b0;
  logic cr_load_in = 1'b0;
  logic cr_quad_in = 1'b0;
  logic [7:0] continuous_read_bits_in = 8'h00;
  wire spi_clk_in, cs_n_in, mosi_in, so_out, so_oe_out, rx_stb;
  wire power_down_out, ready_out, cont_read_out, status_busy_out;
  wire [7:0] rx_byte, oe_cnt;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  int cyc_count = 0;
  always #4 clock_in = ~clock_in;
  fpd_cmd #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEMORY_TYPE_BYTE(TYP), .CAPACITY_BYTE(CAP),
    .UNIQUE_ID(UID)) dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
    .spi_clk_in(spi_clk_in), .cs_n_in(cs_n_in), .mosi_in(mosi_in), .so_out(so_out),
    .so_oe_out(so_oe_out), .busy_in(busy_in), .cr_load_in(cr_load_in),
    .continuous_read_bits_in(continuous_read_bits_in), .cr_quad_in(cr_quad_in),
    .power_down_out(power_down_out), .ready_out(ready_out),
    .cont_read_out(cont_read_out), .status_busy_out(status_busy_out));
  fpd_host_model host_u (.so_in(so_out), .oe_in(so_oe_out), .spi_clk_out(spi_clk_in),
    .cs_n_out(cs_n_in), .mosi_out(mosi_in), .rx_byte_out(rx_byte), .rx_stb_out(rx_stb),
    .oe_cnt_out(oe_cnt));
  task automatic check(input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t exp=%0h got=%0h", $time, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // note n bytes of v, msb byte first, wrapping until rep bytes
  task automatic expect_bytes(input logic [63:0] v, input int n, input int rep);
    for (int j = 0; j < rep; j++) begin
      exp_q.push_back(v[8*(n-1-j%n) +: 8]);
    end
  endtask
  task automatic load_cr(input logic q);
    cr_quad_in = q;
    continuous_read_bits_in = {4'ha, 4'($urandom)};
    cr_load_in = 1'b1;
    cyc(1);
    cr_load_in = 1'b0;
    cyc(2);
  endtask
  // oldest expected byte against each byte the host receives
  always @(posedge rx_stb) begin : watch
    logic [7:0] e;
    #1;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    check(e, rx_byte);
  end
  // hang guard
  always @(posedge clock_in) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(47));
    repeat (6) @(posedge clock_in);
    #1 resetn_in = 1'b1;
    cyc(6);
    check(2'b01, {power_down_out, ready_out});
    host_u.frame(64'hff, 8, 0);
    expect_bytes({MFR, TYP, CAP}, 3, 4);
    host_u.frame(64'h9f, 8, 32);
    expect_bytes({MFR, DEV}, 2, 3);
    host_u.frame({8'h90, 24'h000000}, 32, 24);
    expect_bytes({DEV, MFR}, 2, 3);
    host_u.frame({8'h90, 24'h000001}, 32, 24);
    expect_bytes(DEV, 1, 3);
    host_u.frame({8'hab, 24'($urandom)}, 32, 24);
    expect_bytes(UID, 8, 8);
    host_u.frame({8'h4b, 32'($urandom)}, 40, 64);
    busy_in = 1'b1;
    cyc(2);
    check(1'b1, status_busy_out);
    // refused frames: the undriven line reads as ones through the pull-up
    expect_bytes(64'hff, 1, 2);
    host_u.frame({8'hab, 24'($urandom)}, 32, 16);
    check(8'h00, oe_cnt);
    busy_in = 1'b0;
    cyc(2);
    check(2'b01, {status_busy_out, ready_out});
    host_u.frame({8'hb9, 1'b0}, 9, 0);
    cyc(400);
    check(2'b01, {power_down_out, ready_out});
    host_u.frame(64'hb9, 8, 0);
    cyc(380);
    check(2'b10, {power_down_out, ready_out});
    expect_bytes(64'hff, 1, 3);
    host_u.frame(64'h9f, 8, 24);
    check(8'h00, oe_cnt);
    host_u.frame(64'hab, 8, 0);
    cyc(400);
    check(2'b01, {power_down_out, ready_out});
    host_u.frame(64'hb9, 8, 0);
    cyc(380);
    expect_bytes(64'hff, 1, 1);
    host_u.frame({8'hab, 24'($urandom)}, 32, 8);
    cyc(250);
    check(2'b01, {power_down_out, ready_out});
    load_cr(1'b1);
    check(1'b1, cont_read_out);
    expect_bytes(64'hff, 1, 3);
    host_u.frame(64'h9f, 8, 24);
    check(8'h00, oe_cnt);
    host_u.frame(64'hff, 8, 0);
    cyc(5);
    check(1'b0, cont_read_out);
    load_cr(1'b0);
    host_u.frame(64'hff, 8, 0);
    cyc(5);
    check(1'b1, cont_read_out);
    host_u.frame(64'hffff, 16, 0);
    cyc(5);
    check(1'b0, cont_read_out);
    expect_bytes({MFR, TYP, CAP}, 3, 3);
    host_u.frame(64'h9f, 8, 24);
    cyc(5);
    check(0, exp_q.size());
    give_verdict();
  end
endmodule // testbench
